// ==== core/clock_source_startup_timer.sv ====
// Fuse-driven clock source selection, trim load and start-up delay sequencer with Avalon-MM registers
//
// How it works
// RULE1 - Select values 0100..0111 pick watch crystal
// RULE2 - Select 0110/0111 enables crystal load capacitors
// RULE3 - Crystal: fuse pair sets reset delay
// RULE4 - Crystal wake waits 1K or 32K cycles
// RULE5 - Select 0010 picks the internal RC oscillator
// RULE6 - Divide fuse programmed divides clock by eight
// RULE7 - Every reset copies factory trim into register
// RULE8 - Watchdog and time-out always use watchdog oscillator
// RULE9 - RC: six cycle wake, fuse pair delay
// RULE10 - Delivered default is RC, pair 10
// RULE11 - Programmer uses 1K settings only if stability irrelevant
// RULE12 - Programmer avoids shortest crystal settings near maximum
// RULE13 - Reset delay counts 4096 or 65536 watchdog cycles
// RULE14 - Reset: delay then cycles; wake: cycles only
`timescale 1ns/10ps
`include "clock_source_startup_timer_defines.svh"

module clock_source_startup_timer #(
  parameter clock_source_startup_timer_pkg::cycle_count_t WDT_LONG_CYCLES = `WDT_LONG_CYCLES_DEF,
  parameter clock_source_startup_timer_pkg::cycle_count_t LF_LONG_CYCLES  = `LF_LONG_CYCLES_DEF
) (
  input  wire logic        CLK_SYS_IN,            // System clock, 200 MHz
  input  wire logic        RESET_N_IN,            // Synchronous reset, active low
  input  wire logic        LF_XTAL_CLK_IN,        // Watch crystal oscillator level from crystal_pin_in
  input  wire logic        RC_OSC_CLK_IN,         // Internal RC oscillator level
  input  wire logic        WDT_OSC_CLK_IN,        // Watchdog oscillator level
  input  wire logic [7:0]  FACTORY_TRIM_IN,       // Factory calibration byte
  input  wire logic        SLEEP_REQ_IN,          // Enter power-down or power-save
  input  wire logic        WAKE_IN,               // Wake from sleep
  input  wire logic [3:0]  AVS_ADDRESS_IN,        // Avalon byte address
  input  wire logic        AVS_READ_IN,           // Avalon read
  input  wire logic        AVS_WRITE_IN,          // Avalon write
  input  wire logic [31:0] AVS_WRITEDATA_IN,      // Avalon write data
  input  wire logic [3:0]  AVS_BYTEENABLE_IN,     // Avalon byte enables
  output logic [31:0]      AVS_READDATA_OUT,      // Avalon read data
  output logic             AVS_WAITREQUEST_OUT,   // Avalon wait request
  output logic             EXEC_RUN_OUT,          // Instruction execution released
  output logic             LF_XTAL_SELECT_OUT,    // Watch crystal drives the chip
  output logic             RC_OSC_SELECT_OUT,     // RC oscillator drives the chip
  output logic             LOAD_CAP_EN_OUT,       // Internal capacitors on both crystal pins
  output logic             DIV8_OUT,              // System clock divided by eight
  output logic             SYSCLK_TICK_OUT,       // One system clock cycle
  output logic             WDT_TICK_OUT,          // One watchdog oscillator cycle
  output logic [7:0]       TRIM_OUT,              // oscillator_trim_register value
  output logic             CFG_ERROR_OUT          // Unsupported fuse setting, chip held
);

  clock_source_startup_timer_pkg::fuse_cfg_s    fuse;
  clock_source_startup_timer_pkg::fuse_cfg_s    active;
  clock_source_startup_timer_pkg::state_e       state;
  clock_source_startup_timer_pkg::state_e       next_state;
  clock_source_startup_timer_pkg::status_s      status;
  clock_source_startup_timer_pkg::cycle_count_t delay_target;
  clock_source_startup_timer_pkg::cycle_count_t wake_target;

  logic [7:0] trim;
  logic [2:0] div_cnt;
  logic       ack;
  logic       restart;
  logic       lf_prev;
  logic       rc_prev;
  logic       wdt_prev;
  logic       lf_edge;
  logic       rc_edge;
  logic       wdt_edge;
  logic       src_edge;
  logic       wdt_start;
  logic       cyc_start;
  logic       wdt_done;
  logic       cyc_done;
  logic       wr_take;
  logic       rd_take;
  logic       run;

  // Decoding of the fuse fields
  function automatic logic is_lf(input logic [3:0] sel);
    is_lf = (sel >= `SEL_LF_MIN) && (sel <= `SEL_LF_MAX);  // RULE1
  endfunction

  function automatic logic is_rc(input logic [3:0] sel);
    is_rc = (sel == `SEL_RC);  // RULE5
  endfunction

  function automatic logic cap_enabled(input logic [3:0] sel);
    cap_enabled = (sel == `SEL_CAP_A) || (sel == `SEL_CAP_B);  // RULE2
  endfunction

  // Only the watch crystal and RC sources are supported; the reserved pair is refused
  function automatic logic cfg_error(input clock_source_startup_timer_pkg::fuse_cfg_s cfg);
    logic bad_src;
    logic bad_sut;
    bad_src = !is_lf(cfg.sel) && !is_rc(cfg.sel);
    bad_sut = (cfg.startup_time_fuses != `SUT_NONE) && (cfg.startup_time_fuses != `SUT_SHORT) && (cfg.startup_time_fuses != `SUT_LONG);
    cfg_error = bad_src || bad_sut;
  endfunction

  function automatic clock_source_startup_timer_pkg::cycle_count_t reset_delay(input logic [1:0] startup_time_fuses);
    unique case (startup_time_fuses)
      `SUT_SHORT: reset_delay = `WDT_SHORT_CYCLES;  // RULE13
      `SUT_LONG:  reset_delay = WDT_LONG_CYCLES;    // RULE13
      default:    reset_delay = `CNT_ZERO;
    endcase
  endfunction

  function automatic clock_source_startup_timer_pkg::cycle_count_t wake_cycles(
    input clock_source_startup_timer_pkg::fuse_cfg_s cfg
  );
    if (is_rc(cfg.sel)) begin
      wake_cycles = `RC_WAKE_CYCLES;  // RULE9
    end else if (cfg.sel[`SEL_LOW_BIT]) begin
      wake_cycles = LF_LONG_CYCLES;  // RULE4
    end else begin
      wake_cycles = `LF_SHORT_CYCLES;  // RULE4
    end
  endfunction

  // Oscillator edges; the levels are synchronous to the system clock
  // Detectors follow the pins during reset so that release gives no false edge
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      lf_prev  <= LF_XTAL_CLK_IN;
      rc_prev  <= RC_OSC_CLK_IN;
      wdt_prev <= WDT_OSC_CLK_IN;
    end else begin
      lf_prev  <= LF_XTAL_CLK_IN;
      rc_prev  <= RC_OSC_CLK_IN;
      wdt_prev <= WDT_OSC_CLK_IN;
    end
  end

  assign lf_edge  = LF_XTAL_CLK_IN && !lf_prev;
  assign rc_edge  = RC_OSC_CLK_IN && !rc_prev;
  assign wdt_edge = WDT_OSC_CLK_IN && !wdt_prev;
  assign src_edge = is_rc(active.sel) ? rc_edge : (is_lf(active.sel) && lf_edge);

  // Avalon slave: one wait cycle, then the access completes
  assign AVS_WAITREQUEST_OUT = (AVS_READ_IN || AVS_WRITE_IN) && !ack;
  assign wr_take             = AVS_WRITE_IN && ack && AVS_BYTEENABLE_IN[`LANE0_BIT];
  assign rd_take             = AVS_READ_IN && !ack;

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      ack <= 1'b0;
    end else begin
      ack <= (AVS_READ_IN || AVS_WRITE_IN) && !ack;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      AVS_READDATA_OUT <= '0;
    end else if (rd_take) begin
      unique case (AVS_ADDRESS_IN)
        `FUSE_REG_ADDR:   AVS_READDATA_OUT <= 32'(fuse);
        `TRIM_REG_ADDR:   AVS_READDATA_OUT <= 32'(trim);
        `STATUS_REG_ADDR: AVS_READDATA_OUT <= 32'(status);
        default:          AVS_READDATA_OUT <= '0;
      endcase
    end
  end

  // Fuse bank; new settings act at the next restart
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      fuse <= '{div8_n: `DEFAULT_DIV8_N, startup_time_fuses: `DEFAULT_SUT, sel: `DEFAULT_SEL};  // RULE10
    end else if (wr_take && (AVS_ADDRESS_IN == `FUSE_REG_ADDR)) begin
      fuse <= clock_source_startup_timer_pkg::fuse_cfg_s'(AVS_WRITEDATA_IN[`FUSE_FIELD_MSB:`FUSE_FIELD_LSB]);
    end
  end

  assign restart = wr_take && (AVS_ADDRESS_IN == `CONTROL_REG_ADDR) && AVS_WRITEDATA_IN[`RESTART_BIT];

  // Calibration byte is reloaded on every reset and restart
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      trim <= FACTORY_TRIM_IN;  // RULE7
    end else if (state == clock_source_startup_timer_pkg::ST_LOAD) begin
      trim <= FACTORY_TRIM_IN;  // RULE7
    end else if (wr_take && (AVS_ADDRESS_IN == `TRIM_REG_ADDR)) begin
      trim <= AVS_WRITEDATA_IN[`TRIM_FIELD_MSB:`TRIM_FIELD_LSB];
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      active <= '{div8_n: `DEFAULT_DIV8_N, startup_time_fuses: `DEFAULT_SUT, sel: `DEFAULT_SEL};  // RULE10
    end else if (state == clock_source_startup_timer_pkg::ST_LOAD) begin
      active <= fuse;
    end
  end

  // Start-up sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      clock_source_startup_timer_pkg::ST_LOAD: begin
        if (cfg_error(fuse)) begin
          next_state = clock_source_startup_timer_pkg::ST_HALT;
        end else begin
          next_state = clock_source_startup_timer_pkg::ST_RESET_DELAY;  // RULE14
        end
      end
      clock_source_startup_timer_pkg::ST_RESET_DELAY: begin
        if (wdt_done) begin
          next_state = clock_source_startup_timer_pkg::ST_CYCLE_WAIT;  // RULE14
        end
      end
      clock_source_startup_timer_pkg::ST_CYCLE_WAIT: begin
        if (cyc_done) begin
          next_state = clock_source_startup_timer_pkg::ST_RUN;
        end
      end
      clock_source_startup_timer_pkg::ST_RUN: begin
        if (SLEEP_REQ_IN) begin
          next_state = clock_source_startup_timer_pkg::ST_SLEEP;
        end
      end
      clock_source_startup_timer_pkg::ST_SLEEP: begin
        if (WAKE_IN) begin
          next_state = clock_source_startup_timer_pkg::ST_CYCLE_WAIT;  // RULE14
        end
      end
      clock_source_startup_timer_pkg::ST_HALT: begin
        next_state = clock_source_startup_timer_pkg::ST_HALT;
      end
      default: begin
        next_state = clock_source_startup_timer_pkg::ST_LOAD;
      end
    endcase
    // A restart overrides every other transition
    if (restart) begin
      next_state = clock_source_startup_timer_pkg::ST_LOAD;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      state <= clock_source_startup_timer_pkg::ST_LOAD;
    end else begin
      state <= next_state;
    end
  end

  // Counters start on a clean entry only, never on a restart edge
  assign wdt_start = (state == clock_source_startup_timer_pkg::ST_LOAD) && !restart && !cfg_error(fuse);
  assign cyc_start = !restart && (((state == clock_source_startup_timer_pkg::ST_RESET_DELAY) && wdt_done) ||
                                  ((state == clock_source_startup_timer_pkg::ST_SLEEP) && WAKE_IN));

  assign delay_target = reset_delay(active.startup_time_fuses);  // RULE3 RULE9
  assign wake_target  = wake_cycles(active);

  // Real-time part of the reset delay runs on the watchdog oscillator
  startup_cycle_counter u_reset_delay (
    .clk_in     (CLK_SYS_IN),
    .reset_n_in (RESET_N_IN),
    .start_in   (wdt_start),
    .tick_in    (wdt_edge),  // RULE8 RULE13
    .target_in  (delay_target),
    .done_out   (wdt_done)
  );

  // Oscillator settling is counted in cycles of the selected source
  startup_cycle_counter u_cycle_wait (
    .clk_in     (CLK_SYS_IN),
    .reset_n_in (RESET_N_IN),
    .start_in   (cyc_start),
    .tick_in    (src_edge),  // RULE4 RULE9
    .target_in  (wake_target),
    .done_out   (cyc_done)
  );

  // System clock prescaler fixed by the divide fuse from start-up
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      div_cnt <= `DIV_ZERO;
    end else if (state == clock_source_startup_timer_pkg::ST_LOAD) begin
      div_cnt <= `DIV_ZERO;
    end else if (src_edge) begin
      div_cnt <= (div_cnt == `DIV8_LAST) ? `DIV_ZERO : div_cnt + `DIV_STEP;  // RULE6
    end
  end

  assign run = (state == clock_source_startup_timer_pkg::ST_RUN);

  // One tick per source cycle, or per eighth source cycle when divided
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      SYSCLK_TICK_OUT <= 1'b0;
    end else begin
      SYSCLK_TICK_OUT <= run && src_edge && (active.div8_n || (div_cnt == `DIV8_LAST));  // RULE6
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      WDT_TICK_OUT <= 1'b0;
    end else begin
      WDT_TICK_OUT <= wdt_edge;  // RULE8
    end
  end

  // Source and capacitor controls follow the loaded fuses
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      LF_XTAL_SELECT_OUT <= 1'b0;
      RC_OSC_SELECT_OUT  <= 1'b0;
      LOAD_CAP_EN_OUT    <= 1'b0;
      DIV8_OUT           <= 1'b0;
    end else begin
      LF_XTAL_SELECT_OUT <= is_lf(active.sel);  // RULE1
      RC_OSC_SELECT_OUT  <= is_rc(active.sel);  // RULE5
      LOAD_CAP_EN_OUT    <= cap_enabled(active.sel);  // RULE2
      DIV8_OUT           <= !active.div8_n;  // RULE6
    end
  end

  // Levels follow the state being entered, so they rise with the state itself
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESET_N_IN) begin
      EXEC_RUN_OUT  <= 1'b0;
      CFG_ERROR_OUT <= 1'b0;
    end else begin
      EXEC_RUN_OUT  <= (next_state == clock_source_startup_timer_pkg::ST_RUN);  // RULE14
      CFG_ERROR_OUT <= (next_state == clock_source_startup_timer_pkg::ST_HALT);
    end
  end

  assign TRIM_OUT = trim;

  // Status word as read back over the bus
  assign status = '{run:       EXEC_RUN_OUT,
                    div8:      DIV8_OUT,
                    cfg_error: CFG_ERROR_OUT,
                    rc_sel:    RC_OSC_SELECT_OUT,
                    lf_sel:    LF_XTAL_SELECT_OUT,
                    cap_en:    LOAD_CAP_EN_OUT,
                    state:     state};

endmodule

// ==== core/clock_source_startup_timer_defines.svh ====
// Register map, fuse field layout, delivered defaults and start-up counts of the start-up timer
`ifndef CLOCK_SOURCE_STARTUP_TIMER_DEFINES_SVH
`define CLOCK_SOURCE_STARTUP_TIMER_DEFINES_SVH

`define FUSE_REG_ADDR         4'h0
`define TRIM_REG_ADDR         4'h4
`define STATUS_REG_ADDR       4'h8
`define CONTROL_REG_ADDR      4'hC

`define FUSE_FIELD_LSB        0
`define FUSE_FIELD_MSB        6
`define TRIM_FIELD_LSB        0
`define TRIM_FIELD_MSB        7
`define RESTART_BIT           0
`define LANE0_BIT             0

`define DEFAULT_SEL           4'h2
`define DEFAULT_SUT           2'h2
`define DEFAULT_DIV8_N        1'h0
`define RESET_TRIM            8'h00

`define SEL_LF_MIN            4'h4
`define SEL_LF_MAX            4'h7
`define SEL_CAP_A             4'h6
`define SEL_CAP_B             4'h7
`define SEL_RC                4'h2
`define SEL_LOW_BIT           0

`define SUT_NONE              2'h0
`define SUT_SHORT             2'h1
`define SUT_LONG              2'h2

`define CNT_ZERO              17'h0_0000
`define CNT_STEP              17'h0_0001
`define RC_WAKE_CYCLES        17'h0_0006
`define LF_SHORT_CYCLES       17'h0_0400
`define LF_LONG_CYCLES_DEF    17'h0_8000
`define WDT_SHORT_CYCLES      17'h0_1000
`define WDT_LONG_CYCLES_DEF   17'h1_0000

`define DIV_ZERO              3'h0
`define DIV_STEP              3'h1
`define DIV8_LAST             3'h7

`endif

// ==== core/clock_source_startup_timer_pkg.sv ====
// Types shared by the start-up timer files
package clock_source_startup_timer_pkg;

  typedef logic [16:0] cycle_count_t;

  typedef struct packed {
    logic       div8_n;
    logic [1:0] startup_time_fuses;
    logic [3:0] sel;
  } fuse_cfg_s;

  typedef enum logic [2:0] {
    ST_LOAD,
    ST_RESET_DELAY,
    ST_CYCLE_WAIT,
    ST_RUN,
    ST_SLEEP,
    ST_HALT
  } state_e;

  typedef struct packed {
    logic       run;
    logic       div8;
    logic       cfg_error;
    logic       rc_sel;
    logic       lf_sel;
    logic       cap_en;
    logic [2:0] state;
  } status_s;

endpackage

// ==== core/startup_cycle_counter.sv ====
// Counts tick pulses from a start pulse until a target count is reached
`timescale 1ns/10ps
`include "clock_source_startup_timer_defines.svh"

module startup_cycle_counter (
  input  wire logic                                          clk_in,       // System clock
  input  wire logic                                          reset_n_in,   // Synchronous reset, active low
  input  wire logic                                          start_in,     // Restart counting from zero
  input  wire logic                                          tick_in,      // One counted cycle
  input  wire clock_source_startup_timer_pkg::cycle_count_t  target_in,    // Cycles to wait
  output logic                                               done_out      // Target reached
);

  clock_source_startup_timer_pkg::cycle_count_t count;
  logic                                         busy;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      busy <= 1'b0;
    end else if (start_in) begin
      busy <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      count <= `CNT_ZERO;
    end else if (start_in) begin
      count <= `CNT_ZERO;
    end else if (busy && tick_in && (count != target_in)) begin
      count <= count + `CNT_STEP;
    end
  end

  assign done_out = busy && (count == target_in);

endmodule

// ==== verif/clock_source_startup_timer_monitor.sv ====
// Port-level checks of the start-up timer, bound to its top module
`timescale 1ns/10ps

module clock_source_startup_timer_monitor (
  input wire logic       CLK_SYS_IN,           // System clock
  input wire logic       RESET_N_IN,           // Reset, active low
  input wire logic       RC_OSC_CLK_IN,        // RC oscillator level
  input wire logic       WDT_OSC_CLK_IN,       // Watchdog oscillator level
  input wire logic [7:0] FACTORY_TRIM_IN,      // Factory trim byte
  input wire logic       SLEEP_REQ_IN,         // Sleep request
  input wire logic       AVS_READ_IN,          // Bus read
  input wire logic       AVS_WRITE_IN,         // Bus write
  input wire logic       AVS_WAITREQUEST_OUT,  // Bus wait
  input wire logic       EXEC_RUN_OUT,         // Execution released
  input wire logic       RC_OSC_SELECT_OUT,    // RC selected
  input wire logic       LF_XTAL_SELECT_OUT,   // Watch crystal selected
  input wire logic       LOAD_CAP_EN_OUT,      // Load capacitors on
  input wire logic       DIV8_OUT,             // Divide by eight
  input wire logic       SYSCLK_TICK_OUT,      // System clock tick
  input wire logic       WDT_TICK_OUT,         // Watchdog tick
  input wire logic [7:0] TRIM_OUT,             // Trim register
  input wire logic       CFG_ERROR_OUT         // Unsupported fuses
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESET_N_IN);

  AST_CAP_NEEDS_LF: assert property (LOAD_CAP_EN_OUT |-> LF_XTAL_SELECT_OUT)
    else $error("Load capacitors on without watch crystal");
  AST_ERR_NO_RUN: assert property (CFG_ERROR_OUT |-> !EXEC_RUN_OUT)
    else $error("Execution released with unsupported fuses");
  AST_TRIM_RESET: assert property ($rose(RESET_N_IN) |-> TRIM_OUT == $past(FACTORY_TRIM_IN))
    else $error("Trim not loaded during reset");
  AST_DIV8_SPACING: assert property (DIV8_OUT && SYSCLK_TICK_OUT |=> !SYSCLK_TICK_OUT [*8])
    else $error("Divided ticks too close");
  AST_RC_TICK: assert property (EXEC_RUN_OUT && RC_OSC_SELECT_OUT && !DIV8_OUT && !SLEEP_REQ_IN
    && !AVS_WRITE_IN && $rose(RC_OSC_CLK_IN) |-> ##[1:2] SYSCLK_TICK_OUT)
    else $error("RC edge gave no system tick");
  AST_WDT_TICK: assert property ($rose(WDT_OSC_CLK_IN) |-> ##[1:2] WDT_TICK_OUT)
    else $error("Watchdog edge gave no tick");
  AST_ONE_WAIT: assert property ($rose(AVS_READ_IN || AVS_WRITE_IN) |-> AVS_WAITREQUEST_OUT ##1 !AVS_WAITREQUEST_OUT)
    else $error("Bus answer not after one wait state");
  AST_SLEEP_DROP: assert property (EXEC_RUN_OUT && SLEEP_REQ_IN && !AVS_WRITE_IN |-> ##[1:2] !EXEC_RUN_OUT)
    else $error("Execution not stopped by sleep");
  AST_RESET_DELAY: assert property ($rose(RESET_N_IN) |-> !EXEC_RUN_OUT [*8])
    else $error("Execution released without reset delay");
endmodule

bind clock_source_startup_timer clock_source_startup_timer_monitor u_clock_source_startup_timer_monitor (
  .CLK_SYS_IN(CLK_SYS_IN), .RESET_N_IN(RESET_N_IN), .RC_OSC_CLK_IN(RC_OSC_CLK_IN),
  .WDT_OSC_CLK_IN(WDT_OSC_CLK_IN), .FACTORY_TRIM_IN(FACTORY_TRIM_IN), .SLEEP_REQ_IN(SLEEP_REQ_IN),
  .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
  .EXEC_RUN_OUT(EXEC_RUN_OUT), .RC_OSC_SELECT_OUT(RC_OSC_SELECT_OUT), .LF_XTAL_SELECT_OUT(LF_XTAL_SELECT_OUT),
  .LOAD_CAP_EN_OUT(LOAD_CAP_EN_OUT), .DIV8_OUT(DIV8_OUT), .SYSCLK_TICK_OUT(SYSCLK_TICK_OUT),
  .WDT_TICK_OUT(WDT_TICK_OUT), .TRIM_OUT(TRIM_OUT), .CFG_ERROR_OUT(CFG_ERROR_OUT)
);

// ==== verif/clock_source_startup_timer_tb.sv ====
// Self-checking testbench of the start-up timer
`timescale 1ns/10ps
`include "clock_source_startup_timer_defines.svh"

module clock_source_startup_timer_tb;
  typedef struct {
    logic [6:0] fuse;  // Fuse byte
    logic [3:0] sel;   // Expected {err, cap, rc, lf}
    int         n;     // Watchdog edges
    int         m;     // Source edges
  } row_s;
  row_s        rows [9] = '{'{7'h42, 4'b0010, 0, 6},
                            '{7'h54, 4'b0001, 4096, 1024},
                            '{7'h25, 4'b0001, 16, 16},
                            '{7'h46, 4'b0101, 0, 1024},
                            '{7'h67, 4'b0101, 16, 16}, '{7'h72, 4'b1000, 0, 0},
                            '{7'h43, 4'b1000, 0, 0}, '{7'h48, 4'b1000, 0, 0},
                            '{7'h40, 4'b1000, 0, 0}};
  logic        clk, rst_n, osc, sleep_req, wake, rd, wr;
  logic [7:0]  trim, trim_o;
  logic [3:0]  addr, be;
  logic [31:0] wdata, rdata, q;
  logic        waitreq, run, lf, rc, cap, div8, tick, wtick, err;
  int          bad_count, checked, c, t, w;

  clock_source_startup_timer #(.WDT_LONG_CYCLES(17'h0_0010), .LF_LONG_CYCLES(17'h0_0010)) u_clock_source_startup_timer (
    .CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .LF_XTAL_CLK_IN(osc), .RC_OSC_CLK_IN(osc), .WDT_OSC_CLK_IN(osc),
    .FACTORY_TRIM_IN(trim), .SLEEP_REQ_IN(sleep_req), .WAKE_IN(wake), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq), .EXEC_RUN_OUT(run), .LF_XTAL_SELECT_OUT(lf),
    .RC_OSC_SELECT_OUT(rc), .LOAD_CAP_EN_OUT(cap), .DIV8_OUT(div8), .SYSCLK_TICK_OUT(tick),
    .WDT_TICK_OUT(wtick), .TRIM_OUT(trim_o), .CFG_ERROR_OUT(err));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // All three oscillators rise every second system cycle
  always @(posedge clk) begin
    osc <= ~osc;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_rng(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("Error %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic bus(input logic w_en, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    be <= b;
    wr <= w_en;
    rd <= ~w_en;
    @(posedge clk);
    while (waitreq !== 1'b0 && n < 50) begin
      n++;
      @(posedge clk);
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    cmp_rng(n, 0, 49);
  endtask

  task automatic wait_run();
    repeat (3) @(negedge clk);
    c = 3;
    while (run !== 1'b1 && c < 20000) begin
      @(negedge clk);
      c++;
    end
  endtask

  task automatic ticks(input int cyc);
    t = 0;
    w = 0;
    repeat (cyc) begin
      @(negedge clk);
      if (tick === 1'b1) t++;
      if (wtick === 1'b1) w++;
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    stop_test();
  end

  initial begin
    {rst_n, osc, sleep_req, wake, rd, wr} = 6'h00;
    trim = 8'hA5;
    addr = 4'h0;
    be = 4'hF;
    wdata = 32'h0000_0000;
    bad_count = 0;
    checked = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, `FUSE_REG_ADDR, {25'h0, rows[i].fuse}, 4'hF);
      bus(1'b1, `CONTROL_REG_ADDR, 32'h0000_0001, 4'hF);
      if (rows[i].sel[3]) begin
        repeat (20) @(negedge clk);
        cmp({30'h0, err, run}, 32'h0000_0002);
      end else begin
        wait_run();
        cmp_rng(c, 2 * (rows[i].n + rows[i].m) - 6, 2 * (rows[i].n + rows[i].m) + 6);
        cmp({28'h0, err, cap, rc, lf}, {28'h0, rows[i].sel});
        cmp({31'h0, div8}, {31'h0, ~rows[i].fuse[6]});
        ticks(64);
        cmp_rng(t, rows[i].fuse[6] ? 31 : 3, rows[i].fuse[6] ? 33 : 5);
        cmp_rng(w, 31, 33);
      end
      $display("Row %0d done", i);
    end
    // Second reset while held on unsupported fuses, with a new trim byte
    @(posedge clk);
    rst_n <= 1'b0;
    trim <= 8'h5A;
    repeat (16) @(posedge clk);
    @(negedge clk);
    cmp({23'h0, run, trim_o}, 32'h0000_005A);
    @(posedge clk);
    rst_n <= 1'b1;
    wait_run();
    cmp_rng(c, 38, 50);
    cmp({29'h0, div8, rc, lf}, 32'h0000_0006);
    bus(1'b0, `FUSE_REG_ADDR, 32'h0, 4'hF);
    cmp(q, 32'h0000_0022);
    bus(1'b0, `STATUS_REG_ADDR, 32'h0, 4'hF);
    cmp(q, 32'h0000_01A3);
    $display("Reset test done");
    bus(1'b1, `TRIM_REG_ADDR, 32'h0000_003C, 4'hF);
    bus(1'b1, `TRIM_REG_ADDR, 32'h0000_0011, 4'h0);
    bus(1'b0, `TRIM_REG_ADDR, 32'h0, 4'hF);
    cmp(q, 32'h0000_003C);
    bus(1'b0, 4'h2, 32'h0, 4'hF);
    cmp(q, 32'h0000_0000);
    bus(1'b1, `CONTROL_REG_ADDR, 32'h0000_0000, 4'hF);
    @(negedge clk);
    cmp({31'h0, run}, 32'h0000_0001);
    bus(1'b1, `CONTROL_REG_ADDR, 32'h0000_0001, 4'hF);
    wait_run();
    cmp({24'h0, trim_o}, 32'h0000_005A);
    $display("Register test done");
    @(posedge clk);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    ticks(32);
    cmp_rng(t, 0, 0);
    cmp_rng(w, 15, 17);
    cmp({31'h0, run}, 32'h0000_0000);
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    wait_run();
    cmp_rng(c, 8, 20);
    $display("Sleep test done");
    stop_test();
  end
endmodule
